// file: core/fp_operand_format_unit.sv
// Chosen here: the plain strobed port and the register offsets.
module fp_operand_format_unit
  import fp_format_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_en,
  // core side
  input wire logic fpu_disable_bit,
  input wire logic issue_valid,
  input wire logic [2:0] issue_kind,
  input wire logic issue_double,
  input wire logic [3:0] src_a,
  input wire logic [3:0] src_b,
  input wire logic [3:0] dst,
  input wire logic [5:0] exc_request,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // results
  output logic result_valid,
  output logic [63:0] result_data,
  output logic [2:0] class_a,
  output logic [2:0] class_b,
  output logic disable_exc,
  output logic invalid_exc
);
  // ------------------------------------------------
  // register port map: 0..30 banked regs, 31 csr
  // ------------------------------------------------
  localparam logic [4:0] ADDR_CSR = 5'h1F;

  logic [31:0] fp_control_status_reg;
  logic register_bank_select;
  logic denormal_flush_mode;
  logic [1:0] round_mode;
  logic inv_enable;

  assign register_bank_select = fp_control_status_reg[CSR_FR];
  assign denormal_flush_mode = fp_control_status_reg[CSR_DN];
  assign round_mode = fp_control_status_reg[CSR_RM_LO +: 2];
  assign inv_enable = fp_control_status_reg[CSR_EN_V];

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_READ = 2'h1,
    ST_EXEC = 2'h2
  } state_e;
  state_e state_reg;
  state_e state_next;

  logic [2:0] kind_reg;
  logic dbl_reg;
  logic [3:0] dst_reg;
  logic [5:0] req_reg;
  logic [3:0] srca_reg;
  logic [3:0] srcb_reg;

  // ------------------------------------------------
  // register file with bank mapping
  // ------------------------------------------------
  function automatic logic [4:0] phys(input logic [3:0] idx);
    phys = {register_bank_select, idx};
  endfunction : phys

  logic rf_wr;
  logic [4:0] rf_waddr;
  logic [31:0] rf_wdata;
  logic [4:0] rd_a;
  logic [4:0] rd_b;
  logic [31:0] rf_a;
  logic [31:0] rf_b;
  logic wr_lo_pend;
  logic [4:0] wr_lo_addr;
  logic [31:0] wr_lo_data;

  // ------------------------------------------------
  // read addressing: double uses even/odd pair
  // ------------------------------------------------
  // operands come from the latched indices in ST_READ, so the core
  // may drop its issue fields right after the issue edge
  always_comb
  begin
    rd_a = phys(dbl_reg ? {srca_reg[3:1], 1'b0} : srca_reg);
    rd_b = phys(dbl_reg ? {srca_reg[3:1], 1'b1} : srcb_reg);
    if (state_reg == ST_IDLE && reg_read)
    begin
      rd_a = reg_addr;
    end
  end

  fp_reg_bank bank_u (
    .clock(clock),
    .enable(clock_en),
    .wr_en(rf_wr),
    .wr_addr(rf_waddr),
    .wr_data(rf_wdata),
    .rd_addr_a(rd_a),
    .rd_addr_b(rd_b),
    .rd_data_a(rf_a),
    .rd_data_b(rf_b)
  );

  // ------------------------------------------------
  // classification
  // ------------------------------------------------
  function automatic op_class_e cls_sgl(input logic [31:0] v);
    logic [SGL_EXP_W-1:0] e;
    logic [SGL_FRAC_W-1:0] f;
    e = v[30:23];
    f = v[22:0];
    if (&e)
      cls_sgl = (f == '0) ? CLS_INF :
                (f[SGL_FRAC_W-1] ? CLS_SNAN : CLS_QNAN);
    else if (e == '0)
      cls_sgl = (f == '0) ? CLS_ZERO : CLS_DENORM;
    else
      cls_sgl = CLS_NORMAL;
  endfunction : cls_sgl

  function automatic op_class_e cls_dbl(input logic [63:0] v);
    logic [DBL_EXP_W-1:0] e;
    logic [DBL_FRAC_W-1:0] f;
    e = v[62:52];
    f = v[51:0];
    if (&e)
      cls_dbl = (f == '0) ? CLS_INF :
                (f[DBL_FRAC_W-1] ? CLS_SNAN : CLS_QNAN);
    else if (e == '0)
      cls_dbl = (f == '0) ? CLS_ZERO : CLS_DENORM;
    else
      cls_dbl = CLS_NORMAL;
  endfunction : cls_dbl

  logic [63:0] op_a;
  op_class_e ca;
  op_class_e cb;
  logic exempt;
  logic any_snan;
  logic any_qnan;
  logic [63:0] flushed;
  logic [63:0] res_val;
  logic suppress;
  logic [5:0] exc_now;

  assign op_a = {rf_a, rf_b};
  assign exempt = kind_reg == OP_COPY || kind_reg == OP_ABS ||
                  kind_reg == OP_NEG;

  always_comb
  begin
    if (dbl_reg)
    begin
      ca = cls_dbl(op_a);
      cb = CLS_NORMAL;
    end
    else
    begin
      ca = cls_sgl(rf_a);
      cb = cls_sgl(rf_b);
    end
  end

  assign any_snan = ca == CLS_SNAN || cb == CLS_SNAN;
  assign any_qnan = ca == CLS_QNAN || cb == CLS_QNAN;

  // ------------------------------------------------
  // result selection
  // ------------------------------------------------
  always_comb
  begin
    flushed = dbl_reg ? op_a : {32'h0, rf_a};
    if (!exempt && denormal_flush_mode && ca == CLS_DENORM)
    begin
      flushed = dbl_reg ? {op_a[63], 63'h0} : {32'h0, rf_a[31], 31'h0};
    end
    // with flush off the denormal passes unchanged
    res_val = flushed;
    suppress = 1'b0;
    exc_now = req_reg;
    case (kind_reg)
      OP_COPY: res_val = flushed;
      OP_ABS:
      begin
        if (dbl_reg) res_val[63] = 1'b0;
        else res_val[31] = 1'b0;
      end
      OP_NEG:
      begin
        if (dbl_reg) res_val[63] = ~flushed[63];
        else res_val[31] = ~flushed[31];
      end
      OP_ARITH:
      begin
        if (any_snan && inv_enable)
        begin
          suppress = 1'b1;
          exc_now[EXC_V] = 1'b1;
        end
        else if (any_snan || any_qnan)
        begin
          res_val = dbl_reg ? DBL_QNAN : {32'h0, SGL_QNAN};
        end
      end
      OP_ERROR: exc_now[EXC_E] = 1'b1;
      default: res_val = flushed;
    endcase
  end

  // ------------------------------------------------
  // issue sequencing
  // ------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (issue_valid && !fpu_disable_bit) state_next = ST_READ;
      ST_READ: state_next = ST_EXEC;
      ST_EXEC: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= ST_IDLE;
    else if (clock_en)
      state_reg <= state_next;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      kind_reg <= 3'h0;
      dbl_reg <= 1'b0;
      dst_reg <= 4'h0;
      req_reg <= 6'h0;
      srca_reg <= 4'h0;
      srcb_reg <= 4'h0;
    end
    else if (clock_en && state_reg == ST_IDLE && issue_valid)
    begin
      kind_reg <= issue_kind;
      dbl_reg <= issue_double;
      dst_reg <= dst;
      req_reg <= exc_request;
      srca_reg <= src_a;
      srcb_reg <= src_b;
    end
  end

  // ------------------------------------------------
  // register writes, double in two cycles
  // ------------------------------------------------
  logic do_exec;
  assign do_exec = state_reg == ST_EXEC;

  always_comb
  begin
    rf_wr = 1'b0;
    rf_waddr = reg_addr;
    rf_wdata = reg_wdata;
    if (wr_lo_pend)
    begin
      rf_wr = 1'b1;
      rf_waddr = wr_lo_addr;
      rf_wdata = wr_lo_data;
    end
    else if (do_exec && !suppress)
    begin
      rf_wr = 1'b1;
      rf_waddr = phys(dbl_reg ? {dst_reg[3:1], 1'b0} : dst_reg);
      rf_wdata = dbl_reg ? res_val[63:32] : res_val[31:0];
    end
    else if (reg_write && reg_addr != ADDR_CSR)
    begin
      rf_wr = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_lo_pend <= 1'b0;
      wr_lo_addr <= 5'h0;
      wr_lo_data <= 32'h0;
    end
    else if (clock_en)
    begin
      wr_lo_pend <= do_exec && !suppress && dbl_reg;
      wr_lo_addr <= phys({dst_reg[3:1], 1'b1});
      wr_lo_data <= res_val[31:0];
    end
  end

  // ------------------------------------------------
  // control/status register
  // ------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      fp_control_status_reg <= CSR_RESET;
    else if (clock_en)
    begin
      if (reg_write && reg_addr == ADDR_CSR)
        fp_control_status_reg <= reg_wdata & CSR_WMASK;
      if (state_reg == ST_READ)
        fp_control_status_reg[CSR_CAUSE_LO +: 6] <= 6'h0;
      if (do_exec)
      begin
        fp_control_status_reg[CSR_CAUSE_LO +: 6] <= exc_now;
        // set wins over a same-cycle software write
        fp_control_status_reg[CSR_FLAG_LO +: 5] <=
          (reg_write && reg_addr == ADDR_CSR ?
           reg_wdata[CSR_FLAG_LO +: 5] :
           fp_control_status_reg[CSR_FLAG_LO +: 5]) | exc_now[4:0];
      end
    end
  end

  // ------------------------------------------------
  // outputs
  // ------------------------------------------------
  logic rd_pend;
  logic rd_csr;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_pend <= 1'b0;
      rd_csr <= 1'b0;
    end
    else if (clock_en)
    begin
      rd_pend <= reg_read;
      rd_csr <= reg_addr == ADDR_CSR;
    end
  end
  assign reg_rdata = !rd_pend ? 32'h0 :
                     rd_csr ? fp_control_status_reg : rf_a;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      result_valid <= 1'b0;
      result_data <= 64'h0;
      class_a <= 3'h0;
      class_b <= 3'h0;
      disable_exc <= 1'b0;
      invalid_exc <= 1'b0;
    end
    else if (clock_en)
    begin
      disable_exc <= state_reg == ST_IDLE && issue_valid &&
                     fpu_disable_bit;
      result_valid <= do_exec && !suppress;
      invalid_exc <= do_exec && exc_now[EXC_V] && inv_enable;
      if (do_exec)
      begin
        result_data <= res_val;
        class_a <= ca;
        class_b <= cb;
      end
    end
  end

  // round mode nearest is decoded here, but no logic in this unit reads rm_nearest
  logic rm_nearest;
  assign rm_nearest = round_mode == RM_NEAREST;

  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  refuse_a: assert property (@(posedge clock) disable iff (!reset_n)
    clock_en && state_reg == ST_IDLE && issue_valid && fpu_disable_bit
    |=> disable_exc && state_reg == ST_IDLE)
    else $error("disabled instruction not refused");
  snan_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
    clock_en && do_exec && kind_reg == OP_ARITH && !dbl_reg &&
    any_snan && !inv_enable |=> result_data[31:0] == SGL_QNAN)
    else $error("snan not quieted");
  snan_trap_a: assert property (@(posedge clock) disable iff (!reset_n)
    clock_en && do_exec && kind_reg == OP_ARITH && any_snan &&
    inv_enable |=> invalid_exc && !result_valid)
    else $error("snan trap missing");
  exempt_ops_a: assert property (@(posedge clock) disable iff (!reset_n)
    clock_en && do_exec && exempt |=> !invalid_exc)
    else $error("exempt op trapped");
  qnan_pass_a: assert property (@(posedge clock) disable iff (!reset_n)
    clock_en && do_exec && kind_reg == OP_ARITH && !any_snan &&
    any_qnan |=> !invalid_exc && result_valid)
    else $error("qnan raised exception");
  flush_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
    clock_en && do_exec && kind_reg == OP_ARITH && !dbl_reg &&
    denormal_flush_mode && ca == CLS_DENORM && cb != CLS_SNAN &&
    cb != CLS_QNAN |=> result_data[30:0] == 31'h0)
    else $error("denormal not flushed");
  sticky_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
    clock_en && do_exec && exc_now[EXC_V] |=>
    fp_control_status_reg[CSR_FLAG_LO + EXC_V])
    else $error("flag not set");
  seq_len_a: assert property (@(posedge clock) disable iff (!reset_n)
    clock_en && state_reg == ST_READ ##1 clock_en |->
    state_reg == ST_EXEC)
    else $error("sequence broken");
endmodule : fp_operand_format_unit

// file: core/fp_format_pkg.sv
// Functional notes
// - disable bit set refuses instructions, raises exception
// - single: sign, 8-bit exponent, 23-bit fraction, bias 127
// - double: sign bit 63, 11/52 bits, bias 1023
// - stored exponent is true exponent plus bias
// - all-ones exponent: nan if fraction nonzero, else infinity
// - zero exponent: denormal if fraction nonzero, else zero
// - fraction msb one means signalling, zero means quiet
// - signalling nan, invalid enable off: quiet nan result
// - signalling nan, invalid enable on: exception, no write
// - copy, abs, negate exempt from nan handling
// - quiet nan input gives quiet nan, no exception
// - fixed quiet nan encodings for single and double
// - denormal mode one flushes denormals to zero
// - denormal mode zero keeps denormal values
// - thirty-two 32-bit registers in two banks
// - two rounding modes: nearest and toward zero
// - six exception sources detected
// - bank select swaps primary and extended banks
// - cause cleared per instruction, flags sticky
// - invalid enable bit 11, other enables 10..7
package fp_format_pkg;
  // ----------------------------------------
  // formats
  // ----------------------------------------
  localparam int SGL_EXP_W = 8;
  localparam int SGL_FRAC_W = 23;
  localparam int SGL_BIAS = 127;
  localparam int SGL_EMIN = -126;
  localparam int DBL_EXP_W = 11;
  localparam int DBL_FRAC_W = 52;
  localparam int DBL_BIAS = 1023;
  localparam int DBL_EMIN = -1022;
  localparam logic [31:0] SGL_QNAN = 32'h7FBFFFFF;
  localparam logic [63:0] DBL_QNAN = 64'h7FF7FFFF_FFFFFFFF;
  // ----------------------------------------
  // control/status word fields
  // ----------------------------------------
  localparam int CSR_RM_LO = 0;
  localparam int CSR_FLAG_LO = 2;
  localparam int CSR_EN_LO = 7;
  localparam int CSR_EN_V = 11;
  localparam int CSR_CAUSE_LO = 12;
  localparam int CSR_DN = 18;
  localparam int CSR_PR = 19;
  localparam int CSR_SZ = 20;
  localparam int CSR_FR = 21;
  localparam logic [31:0] CSR_RESET = 32'h00040001;
  localparam logic [31:0] CSR_WMASK = 32'h003FFFFF;
  // exception bit order inside cause: E V Z O U I
  localparam int EXC_I = 0;
  localparam int EXC_U = 1;
  localparam int EXC_O = 2;
  localparam int EXC_Z = 3;
  localparam int EXC_V = 4;
  localparam int EXC_E = 5;
  localparam logic [1:0] RM_NEAREST = 2'h0;
  localparam logic [1:0] RM_ZERO = 2'h1;
  localparam int NREGS = 32;
  localparam int BANK_REGS = 16;

  typedef enum logic [2:0] {
    CLS_ZERO = 3'h0,
    CLS_DENORM = 3'h1,
    CLS_NORMAL = 3'h2,
    CLS_INF = 3'h3,
    CLS_QNAN = 3'h4,
    CLS_SNAN = 3'h5
  } op_class_e;

  typedef enum logic [2:0] {
    OP_COPY = 3'h0,
    OP_ABS = 3'h1,
    OP_NEG = 3'h2,
    OP_ARITH = 3'h3,
    OP_ERROR = 3'h4
  } op_kind_e;
endpackage : fp_format_pkg

// file: core/fp_reg_bank.sv
module fp_reg_bank
  import fp_format_pkg::*;
(
  // clock
  input wire logic clock,
  input wire logic enable,
  // write port
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [31:0] wr_data,
  // read ports
  input wire logic [4:0] rd_addr_a,
  input wire logic [4:0] rd_addr_b,
  output logic [31:0] rd_data_a,
  output logic [31:0] rd_data_b
);
  logic [31:0] mem [NREGS];

  always_ff @(posedge clock)
  begin
    if (enable && wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (enable)
    begin
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end
endmodule : fp_reg_bank

// file: verif/core_issue_model.sv
module core_issue_model
  import fp_format_pkg::*;
(
  // clock
  input wire logic clock,
  // issue side
  output logic fpu_disable_bit,
  output logic issue_valid,
  output logic [2:0] issue_kind,
  output logic issue_double,
  output logic [3:0] src_a,
  output logic [3:0] src_b,
  output logic [3:0] dst,
  output logic [5:0] exc_request,
  // answers
  input wire logic result_valid,
  input wire logic [63:0] result_data,
  input wire logic [2:0] class_a,
  input wire logic [2:0] class_b,
  input wire logic disable_exc,
  input wire logic invalid_exc
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    fpu_disable_bit = 1'b0;
    issue_valid = 1'b0;
    {issue_kind, issue_double, src_a, src_b, dst, exc_request} = '0;
  end

  // one issue, then a quiet window long enough for any answer
  task automatic issue(input logic [2:0] k, input logic d,
    input logic [3:0] a, b, w, input logic [5:0] e, output logic rv,
    output logic [63:0] rd, output logic [2:0] ca, cb,
    output logic inv, dis);
    {rv, inv, dis, ca, cb} = '0;
    rd = '0;
    @(posedge clock);
    issue_valid <= 1'b1;
    issue_kind <= k;
    issue_double <= d;
    src_a <= a;
    src_b <= b;
    dst <= w;
    exc_request <= e;
    @(posedge clock);
    issue_valid <= 1'b0;
    // stale fields are scrambled so nothing leans on them
    issue_kind <= ~k;
    issue_double <= ~d;
    src_a <= ~a;
    src_b <= ~b;
    dst <= ~w;
    exc_request <= ~e;
    repeat (8)
    begin
      @(negedge clock);
      if (result_valid === 1'b1)
      begin
        rv = 1'b1;
        rd = result_data;
        ca = class_a;
        cb = class_b;
      end
      inv = inv | (invalid_exc === 1'b1);
      dis = dis | (disable_exc === 1'b1);
    end
  endtask : issue
endmodule : core_issue_model

// file: verif/fp_operand_format_unit_tb.sv
module fp_operand_format_unit_tb
  import fp_format_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset_n, clock_en, fpu_disable_bit, issue_valid;
  logic issue_double, reg_write, reg_read, result_valid;
  logic disable_exc, invalid_exc, rv, inv, dis;
  logic [2:0] issue_kind, class_a, class_b, ca, cb;
  logic [3:0] src_a, src_b, dst;
  logic [5:0] exc_request;
  logic [4:0] reg_addr, flags;
  logic [31:0] reg_wdata, reg_rdata, v, w, w2;
  logic [63:0] result_data, rd;
  int n_fail, checks_done, seed;
  logic [31:0] corner [12] = '{32'h00000000, 32'h80000000, 32'h00000001,
    32'h807FFFFF, 32'h00800000, 32'h7F7FFFFF, 32'h7F800000, 32'hFF800000,
    32'h7F800001, 32'h7FBFFFFF, 32'h7FC00000, 32'hFFFFFFFF};

  fp_operand_format_unit dut (.clock(clock), .reset_n(reset_n),
    .clock_en(clock_en), .fpu_disable_bit(fpu_disable_bit),
    .issue_valid(issue_valid), .issue_kind(issue_kind),
    .issue_double(issue_double), .src_a(src_a), .src_b(src_b),
    .dst(dst), .exc_request(exc_request), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .result_valid(result_valid),
    .result_data(result_data), .class_a(class_a), .class_b(class_b),
    .disable_exc(disable_exc), .invalid_exc(invalid_exc));

  core_issue_model core_m (.clock(clock), .fpu_disable_bit(fpu_disable_bit),
    .issue_valid(issue_valid), .issue_kind(issue_kind),
    .issue_double(issue_double), .src_a(src_a), .src_b(src_b),
    .dst(dst), .exc_request(exc_request), .result_valid(result_valid),
    .result_data(result_data), .class_a(class_a), .class_b(class_b),
    .disable_exc(disable_exc), .invalid_exc(invalid_exc));

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [2:0] cls32(input logic [31:0] x);
    if (x[30:23] == 8'hFF)
      return (x[22:0] == 0) ? CLS_INF : (x[22] ? CLS_SNAN : CLS_QNAN);
    if (x[30:23] == 8'h00)
      return (x[22:0] == 0) ? CLS_ZERO : CLS_DENORM;
    return CLS_NORMAL;
  endfunction : cls32

  function automatic logic [2:0] cls64(input logic [63:0] x);
    if (x[62:52] == 11'h7FF)
      return (x[51:0] == 0) ? CLS_INF : (x[51] ? CLS_SNAN : CLS_QNAN);
    if (x[62:52] == 11'h000)
      return (x[51:0] == 0) ? CLS_ZERO : CLS_DENORM;
    return CLS_NORMAL;
  endfunction : cls64

  task automatic check(input logic [63:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask : reg_rd

  task automatic op(input int k, input logic d, input int a, b, c,
    input logic [5:0] e);
    core_m.issue(3'(k), d, 4'(a), 4'(b), 4'(c), e, rv, rd, ca, cb, inv, dis);
  endtask : op

  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail++;
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = 32'hEC6C;
    {reset_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    clock_en = 1'b1;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    reg_rd(5'h1F, v);
    check(v, CSR_RESET);
    w = $random(seed);
    reg_wr(5'h1F, w);
    reg_rd(5'h1F, v);
    check(v, w & CSR_WMASK);
    reg_wr(5'h1F, CSR_RESET);
    for (int i = 0; i < 8; i++)
    begin
      w2 = 32'($unsigned($random(seed)) % 31);
      w = $random(seed);
      reg_wr(w2[4:0], w);
      reg_rd(w2[4:0], v);
      check(v, w);
    end
    // classes and the exempt copy, abs and negate
    for (int i = 0; i < 24; i++)
    begin
      v = (i < 12) ? corner[i] : $random(seed);
      reg_wr(5'h01, v);
      for (int k = 0; k < 3; k++)
      begin
        op(k, 1'b0, 1, 1, 2, 6'h00);
        check(ca, cls32(v));
        check(rd[31:0], (k == 0) ? v : {k == 2 && !v[31], v[30:0]});
        check({rv, inv}, 2'b10);
      end
    end
    // nan propagation with the invalid enable off and on
    reg_wr(5'h01, 32'h7FC00001);
    reg_wr(5'h02, 32'h3F800000);
    reg_wr(5'h03, 32'h7F800001);
    for (int ev = 0; ev < 2; ev++)
    begin
      reg_wr(5'h1F, CSR_RESET | (32'(ev) << CSR_EN_V));
      reg_wr(5'h04, 32'h12345678);
      op(3, 1'b0, 1, 2, 4, 6'h00);
      if (ev == 0)
        check({rv, inv, rd[31:0]}, {2'b10, SGL_QNAN});
      else
        check({rv, inv}, 2'b01);
      reg_rd(5'h04, v);
      check(v, (ev == 0) ? SGL_QNAN : 32'h12345678);
      op(3, 1'b0, 3, 2, 4, 6'h00);
      check({rv, inv, rd[31:0]}, {2'b10, SGL_QNAN});
      check(cb, CLS_NORMAL);
    end
    // denormal flushed by arithmetic only while the mode bit is set
    reg_wr(5'h01, 32'h807FFFFF);
    for (int dn = 0; dn < 2; dn++)
    begin
      reg_wr(5'h1F, CSR_RESET ^ (32'(dn) << CSR_DN));
      op(3, 1'b0, 1, 2, 5, 6'h00);
      check({ca, rd[31:0]}, {CLS_DENORM, (dn == 0) ? 32'h80000000 :
        32'h807FFFFF});
    end
    reg_wr(5'h1F, CSR_RESET);
    // double pairs
    reg_wr(5'h04, 32'h7FF80000);
    reg_wr(5'h05, 32'h00000000);
    reg_wr(5'h06, 32'h3FF00000);
    reg_wr(5'h07, 32'h00000000);
    op(3, 1'b1, 4, 6, 8, 6'h00);
    check(rd, DBL_QNAN);
    check({ca, cb}, {CLS_SNAN, CLS_NORMAL});
    reg_rd(5'h08, v);
    check(v, DBL_QNAN[63:32]);
    reg_rd(5'h09, v);
    check(v, DBL_QNAN[31:0]);
    for (int i = 0; i < 6; i++)
    begin
      w = (i == 0) ? 32'h000FFFFF : (i == 1) ? 32'h7FF00000 : $random(seed);
      w2 = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $random(seed);
      reg_wr(5'h0A, w);
      reg_wr(5'h0B, w2);
      op(0, 1'b1, 10, 0, 12, 6'h00);
      check(rd, {w, w2});
      check(ca, cls64({w, w2}));
    end
    // bank swap
    reg_wr(5'h1F, CSR_RESET | (32'h1 << CSR_FR));
    reg_wr(5'h13, 32'hA5A5A5A5);
    reg_wr(5'h03, 32'h5A5A5A5A);
    op(0, 1'b0, 3, 0, 5, 6'h00);
    check(rd[31:0], 32'hA5A5A5A5);
    reg_rd(5'h15, v);
    check(v, 32'hA5A5A5A5);
    reg_wr(5'h1F, CSR_RESET);
    // cause cleared per operation, flags sticky
    flags = '0;
    for (int i = 0; i < 8; i++)
    begin
      op((i == 7) ? 4 : 3, 1'b0, 2, 2, 13, (i < 6) ? 6'(1 << i) : 6'h00);
      flags = flags | ((i < 5) ? 5'(1 << i) : 5'h00);
      reg_rd(5'h1F, v);
      check(v, CSR_RESET | ((i < 6) ? 32'(1 << (i + CSR_CAUSE_LO)) :
        (i == 7) ? 32'(1 << (EXC_E + CSR_CAUSE_LO)) : 32'h0)
        | (32'(flags) << CSR_FLAG_LO));
    end
    reg_wr(5'h1F, CSR_RESET);
    // disabled unit refuses
    @(posedge clock);
    core_m.fpu_disable_bit <= 1'b1;
    op(3, 1'b0, 2, 2, 14, 6'h00);
    check({rv, dis}, 2'b01);
    @(posedge clock);
    core_m.fpu_disable_bit <= 1'b0;
    // frozen clock enable leaves registers alone
    reg_wr(5'h0E, 32'h0BADF00D);
    @(posedge clock);
    clock_en <= 1'b0;
    op(0, 1'b0, 2, 0, 14, 6'h00);
    clock_en <= 1'b1;
    reg_rd(5'h0E, v);
    check({rv, v}, {1'b0, 32'h0BADF00D});
    stop_test();
  end
endmodule : fp_operand_format_unit_tb
